// file: design/irt_cfg.svh
`ifndef IRT_CFG_SVH
`define IRT_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define IRT_OFS_TRIM_HIGH  4'h0
`define IRT_OFS_TRIM_LOW   4'h4
`define IRT_OFS_PROTECT    4'h8
`define IRT_OFS_CLK_STAT   4'hC

// ----------------------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------------------
`define IRT_TRIM_RST       16'h0000
`define IRT_PROTECT_RST    1'h0
`define IRT_PLL_CLOCK_SELECT_RST     1'h0
`define IRT_UNLOCK_KEY     8'h26
`define IRT_TRIM_WMASK     16'hFBFF

// ----------------------------------------------------------------------------
// Field positions in the combined 16-bit trim word
// ----------------------------------------------------------------------------
`define IRT_TC_MSB         15
`define IRT_TC_LSB         11
`define IRT_RSVD_BIT       10
`define IRT_FREQ_MSB       9
`define IRT_FREQ_LSB       0
`define IRT_COARSE_MSB     9
`define IRT_COARSE_LSB     6
`define IRT_FINE_MSB       5
`define IRT_FINE_LSB       0
`define IRT_TC_OFF_A       5'h00
`define IRT_TC_OFF_B       5'h10

// ----------------------------------------------------------------------------
// Clock status register bits
// ----------------------------------------------------------------------------
`define IRT_CS_PLL_CLOCK_SELECT_BIT  0
`define IRT_CS_LOCK_BIT    1
`define IRT_CS_OSCUP_BIT   2

`endif

// file: design/irt_pkg.sv
package irt_pkg;

  // --------------------------------------------------------------------------
  // Factory load sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ld_wait = 2'b00,
    ld_req  = 2'b01,
    ld_done = 2'b10
  } irt_load_state_e;

endpackage : irt_pkg

// file: design/irt_load_if.sv
interface irt_load_if;
  logic        load_valid;
  logic [15:0] load_data;
  logic        load_done;

  modport loader (
    output load_valid,
    output load_data,
    output load_done
  );

  modport core (
    input  load_valid,
    input  load_data,
    input  load_done
  );
endinterface : irt_load_if

// file: design/irt_factory_load.sv
`include "irt_cfg.svh"

module irt_factory_load (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Flash read port
  input  wire logic        flash_ack_i,
  input  wire logic [15:0] flash_data_i,
  output logic             flash_req_o,
  // Load result
  irt_load_if.loader       ld
);

  irt_pkg::irt_load_state_e state;

  // --------------------------------------------------------------------------
  // One flash read after reset release
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state         <= irt_pkg::ld_wait;
      flash_req_o   <= 1'b0;
      ld.load_valid <= 1'b0;
      ld.load_data  <= `IRT_TRIM_RST;
      ld.load_done  <= 1'b0;
    end else begin
      ld.load_valid <= 1'b0;
      unique case (state)
        irt_pkg::ld_wait: begin
          state       <= irt_pkg::ld_req;
          flash_req_o <= 1'b1;
        end
        irt_pkg::ld_req: begin
          if (flash_ack_i) begin
            state         <= irt_pkg::ld_done;
            flash_req_o   <= 1'b0;
            ld.load_valid <= 1'b1;
            ld.load_data  <= flash_data_i;
            ld.load_done  <= 1'b1;
          end
        end
        irt_pkg::ld_done: begin
          state <= irt_pkg::ld_done;
        end
        default: begin
          state <= irt_pkg::ld_wait;
        end
      endcase
    end
  end

endmodule : irt_factory_load

// file: design/irt_trim_top.sv
// Overview of operation
// - After system reset is released the trim pair is loaded once from the factory value in flash.
// - Trim registers read once the factory load is done, and a write lands only while the protect bit is 0.
// - Any trim write while the PLL clock select is 1 clears the lock and oscillator-up flags, except a flag whose status pin rise lands in the same cycle.
// - Bits 15 to 11 of the trim pair hold the 5-bit temperature-coefficient trim.
// - Bits 9 to 0 of the trim pair hold the 10-bit frequency trim driven to the oscillator.
// - Frequency trim bits 9 to 6 form the coarse step of about 6 percent.
// - Frequency trim bits 5 to 0 form the fine step of about 0.3 percent.
// - Coefficient codes 00000 and 10000 switch temperature compensation off.
// - Top coefficient bit 0 steers the shift negative, 1 positive, by the four low bits.
// - Writing 0x26 to the protection register clears the protect bit, any other write sets it.
`include "irt_cfg.svh"

module irt_trim_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Flash factory value port
  input  wire logic              flash_ack_i,
  input  wire logic [15:0]       flash_data_i,
  output logic                   flash_req_o,
  // PLL and oscillator status pins
  input  wire logic              pll_locked_i,
  input  wire logic              osc_stable_i,
  // Clock control outputs
  output logic                   pll_clock_select_o,
  output logic                   pll_lock_flag_o,
  output logic                   osc_up_flag_o,
  output logic                   config_protect_bit_o,
  // Oscillator trim outputs
  output logic      [9:0]        ref_freq_trim_o,
  output logic      [3:0]        coarse_trim_o,
  output logic      [5:0]        fine_trim_o,
  output logic      [4:0]        temp_coeff_trim_o,
  output logic                   tc_comp_enable_o,
  output logic                   tc_shift_positive_o,
  output logic      [3:0]        tc_shift_step_o
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("ADDR_W must be at least 4");
  end

  // --------------------------------------------------------------------------
  // Factory load
  // --------------------------------------------------------------------------
  irt_load_if ld_bus ();

  irt_factory_load u_load (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .flash_ack_i  (flash_ack_i),
    .flash_data_i (flash_data_i),
    .flash_req_o  (flash_req_o),
    .ld           (ld_bus.loader)
  );

  // --------------------------------------------------------------------------
  // Status pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] stat_pin;
  logic [1:0] stat_s1;
  logic [1:0] stat_s2;
  logic [1:0] stat_s3;
  logic [1:0] stat_stable;
  logic [1:0] stat_rise;

  assign stat_pin = {osc_stable_i, pll_locked_i};

  for (genvar gi = 0; gi < 2; gi++) begin : g_sync
    always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
        stat_s1[gi]     <= 1'b0;
        stat_s2[gi]     <= 1'b0;
        stat_s3[gi]     <= 1'b0;
        stat_stable[gi] <= 1'b0;
      end else begin
        stat_s1[gi] <= stat_pin[gi];
        stat_s2[gi] <= stat_s1[gi];
        stat_s3[gi] <= stat_s2[gi];
        if (stat_s2[gi] == stat_s3[gi]) begin
          stat_stable[gi] <= stat_s2[gi];
        end
      end
    end
    assign stat_rise[gi] = (stat_s2[gi] == stat_s3[gi]) & stat_s2[gi] & ~stat_stable[gi];
  end

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        bus_go;
  logic        wr_go;
  logic        hit_hi;
  logic        hit_lo;
  logic        hit_config_protect_bit;
  logic        hit_cs;
  logic        upper_zero;
  logic        wr_trim;
  logic [15:0] trim_q;
  logic        protect_q;
  logic [31:0] next_rdata;

  assign upper_zero = (wb_adr_i >> 4) == '0;
  assign hit_hi     = upper_zero & (wb_adr_i[3:0] == `IRT_OFS_TRIM_HIGH);
  assign hit_lo     = upper_zero & (wb_adr_i[3:0] == `IRT_OFS_TRIM_LOW);
  assign hit_config_protect_bit   = upper_zero & (wb_adr_i[3:0] == `IRT_OFS_PROTECT);
  assign hit_cs     = upper_zero & (wb_adr_i[3:0] == `IRT_OFS_CLK_STAT);

  // Requests wait until the factory value is in place
  // The load strobe still stands in the cycle before the trim holds the value
  assign bus_go  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ld_bus.load_done &
                   ~ld_bus.load_valid;
  assign wr_go   = bus_go & wb_we_i & wb_sel_i[0];
  assign wr_trim = wr_go & (hit_hi | hit_lo);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_go;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_hi) begin
      next_rdata[7:0] = trim_q[15:8];
    end else if (hit_lo) begin
      next_rdata[7:0] = trim_q[7:0];
    end else if (hit_config_protect_bit) begin
      next_rdata[0] = protect_q;
    end else if (hit_cs) begin
      next_rdata[`IRT_CS_PLL_CLOCK_SELECT_BIT] = pll_clock_select_o;
      next_rdata[`IRT_CS_LOCK_BIT]   = pll_lock_flag_o;
      next_rdata[`IRT_CS_OSCUP_BIT]  = osc_up_flag_o;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_go & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Trim register pair
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      trim_q <= `IRT_TRIM_RST;
    end else if (ld_bus.load_valid) begin
      trim_q <= ld_bus.load_data & `IRT_TRIM_WMASK;
    end else if (wr_go & ~protect_q) begin
      if (hit_hi) begin
        trim_q[15:8] <= wb_dat_i[7:0] & 8'(`IRT_TRIM_WMASK >> 8);
      end
      if (hit_lo) begin
        trim_q[7:0] <= wb_dat_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Protection register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      protect_q <= `IRT_PROTECT_RST;
    end else if (wr_go & hit_config_protect_bit) begin
      protect_q <= (wb_dat_i[7:0] != `IRT_UNLOCK_KEY);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      config_protect_bit_o <= `IRT_PROTECT_RST;
    end else if (wr_go & hit_config_protect_bit) begin
      config_protect_bit_o <= (wb_dat_i[7:0] != `IRT_UNLOCK_KEY);
    end
  end

  // --------------------------------------------------------------------------
  // Clock select and status flags
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pll_clock_select_o <= `IRT_PLL_CLOCK_SELECT_RST;
    end else if (wr_go & hit_cs) begin
      pll_clock_select_o <= wb_dat_i[`IRT_CS_PLL_CLOCK_SELECT_BIT];
    end
  end

  // Set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pll_lock_flag_o <= 1'b0;
      osc_up_flag_o   <= 1'b0;
    end else begin
      pll_lock_flag_o <= stat_rise[0] |
                         (pll_lock_flag_o & ~(wr_trim & pll_clock_select_o));
      osc_up_flag_o   <= stat_rise[1] |
                         (osc_up_flag_o & ~(wr_trim & pll_clock_select_o));
    end
  end

  // --------------------------------------------------------------------------
  // Oscillator trim outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ref_freq_trim_o   <= 10'h000;
      coarse_trim_o     <= 4'h0;
      fine_trim_o       <= 6'h00;
      temp_coeff_trim_o <= 5'h00;
    end else begin
      ref_freq_trim_o   <= trim_q[`IRT_FREQ_MSB:`IRT_FREQ_LSB];
      coarse_trim_o     <= trim_q[`IRT_COARSE_MSB:`IRT_COARSE_LSB];
      fine_trim_o       <= trim_q[`IRT_FINE_MSB:`IRT_FINE_LSB];
      temp_coeff_trim_o <= trim_q[`IRT_TC_MSB:`IRT_TC_LSB];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tc_comp_enable_o    <= 1'b0;
      tc_shift_positive_o <= 1'b0;
      tc_shift_step_o     <= 4'h0;
    end else begin
      tc_comp_enable_o    <= (trim_q[`IRT_TC_MSB:`IRT_TC_LSB] != `IRT_TC_OFF_A) &&
                             (trim_q[`IRT_TC_MSB:`IRT_TC_LSB] != `IRT_TC_OFF_B);
      tc_shift_positive_o <= trim_q[`IRT_TC_MSB];
      tc_shift_step_o     <= trim_q[`IRT_TC_MSB-1:`IRT_TC_LSB];
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_factory_load;
    ld_bus.load_valid;
  endsequence

  sequence s_key_write;
    wr_go && hit_config_protect_bit && (wb_dat_i[7:0] == `IRT_UNLOCK_KEY);
  endsequence

  sequence s_locked_hi_write;
    wr_go && hit_hi && protect_q;
  endsequence

  property p_factory_load;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    s_factory_load |=> trim_q == ($past(ld_bus.load_data) & `IRT_TRIM_WMASK);
  endproperty
  a_factory_load: assert property (p_factory_load)
    else $error("trim pair not loaded from flash value");

  property p_locked_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    s_locked_hi_write |=> $stable(trim_q);
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("trim changed while protected");

  property p_open_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    wr_go && hit_lo && !protect_q |=> trim_q[7:0] == $past(wb_dat_i[7:0]);
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("unprotected trim write lost");

  property p_flag_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    wr_trim && pll_clock_select_o && !stat_rise[0] && !stat_rise[1]
      |=> !pll_lock_flag_o && !osc_up_flag_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("status flags not cleared by trim write");

  property p_tc_field;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 temp_coeff_trim_o == $past(trim_q[15:11]);
  endproperty
  a_tc_field: assert property (p_tc_field)
    else $error("coefficient trim output wrong");

  property p_freq_field;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    ##1 ref_freq_trim_o == $past(trim_q[9:0]);
  endproperty
  a_freq_field: assert property (p_freq_field)
    else $error("frequency trim output wrong");

  property p_coarse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    coarse_trim_o == ref_freq_trim_o[9:6];
  endproperty
  a_coarse: assert property (p_coarse)
    else $error("coarse trim mismatch");

  property p_fine;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    fine_trim_o == ref_freq_trim_o[5:0];
  endproperty
  a_fine: assert property (p_fine)
    else $error("fine trim mismatch");

  property p_tc_off;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    tc_comp_enable_o == (temp_coeff_trim_o[3:0] != 4'h0);
  endproperty
  a_tc_off: assert property (p_tc_off)
    else $error("compensation enable wrong");

  property p_tc_dir;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    tc_shift_positive_o == temp_coeff_trim_o[4] &&
    tc_shift_step_o == temp_coeff_trim_o[3:0];
  endproperty
  a_tc_dir: assert property (p_tc_dir)
    else $error("coefficient direction wrong");

  property p_key_unlock;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    s_key_write |=> !protect_q ##0 !config_protect_bit_o;
  endproperty
  a_key_unlock: assert property (p_key_unlock)
    else $error("key write did not unlock");

  property p_other_lock;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    wr_go && hit_config_protect_bit && (wb_dat_i[7:0] != `IRT_UNLOCK_KEY) |=> protect_q;
  endproperty
  a_other_lock: assert property (p_other_lock)
    else $error("non-key write did not lock");

  property p_reserved;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !trim_q[`IRT_RSVD_BIT];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved trim bit set");

  property p_ack_pulse;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

endmodule : irt_trim_top

// file: test/irt_trim_top_tb_top.sv
module irt_trim_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 5;
  logic              core_clk_i;
  logic              reset_n_i;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              flash_ack_i;
  logic [15:0]       flash_data_i;
  logic              flash_req_o;
  logic              pll_locked_i;
  logic              osc_stable_i;
  logic              pll_clock_select_o;
  logic              pll_lock_flag_o;
  logic              osc_up_flag_o;
  logic              config_protect_bit_o;
  logic [9:0]        ref_freq_trim_o;
  logic [3:0]        coarse_trim_o;
  logic [5:0]        fine_trim_o;
  logic [4:0]        temp_coeff_trim_o;
  logic              tc_comp_enable_o;
  logic              tc_shift_positive_o;
  logic [3:0]        tc_shift_step_o;
  logic [15:0]       exp_trim;
  int                err_count;
  int                cmp_count;
  int                cyc_cnt;

  irt_trim_top #(.ADDR_W(ADDR_W)) irt_trim_top_inst (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_ack_i(flash_ack_i), .flash_data_i(flash_data_i), .flash_req_o(flash_req_o),
    .pll_locked_i(pll_locked_i), .osc_stable_i(osc_stable_i),
    .pll_clock_select_o(pll_clock_select_o), .pll_lock_flag_o(pll_lock_flag_o),
    .osc_up_flag_o(osc_up_flag_o), .config_protect_bit_o(config_protect_bit_o),
    .ref_freq_trim_o(ref_freq_trim_o), .coarse_trim_o(coarse_trim_o),
    .fine_trim_o(fine_trim_o), .temp_coeff_trim_o(temp_coeff_trim_o),
    .tc_comp_enable_o(tc_comp_enable_o), .tc_shift_positive_o(tc_shift_positive_o),
    .tc_shift_step_o(tc_shift_step_o)
  );

  // --------------------------------------------------------------------------
  // Clock, timeout and reporting
  // --------------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run;
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge core_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // --------------------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [ADDR_W-1:0] adr, input logic [3:0] sel,
                         input logic [7:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wdat};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 200);
    check("bus_ack", {31'h0, wb_ack_o}, 32'h1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_dat_i <= ~{24'h000000, wdat};
    @(posedge core_clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [ADDR_W-1:0] adr, input logic [7:0] val);
    logic [31:0] v;
    wb_xfer(1'b1, adr, 4'hF, val, v);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] adr, output logic [31:0] v);
    wb_xfer(1'b0, adr, 4'hF, 8'h00, v);
  endtask : rd

  task automatic chk_trim;
    logic [31:0] v;
    rd(5'h00, v);
    check("trim_high", v, {24'h0, exp_trim[15:8]});
    rd(5'h04, v);
    check("trim_low", v, {24'h0, exp_trim[7:0]});
    check("ref_freq_trim", ref_freq_trim_o, exp_trim[9:0]);
    check("coarse_trim", coarse_trim_o, exp_trim[9:6]);
    check("fine_trim", fine_trim_o, exp_trim[5:0]);
    check("temp_coeff_trim", temp_coeff_trim_o, exp_trim[15:11]);
    check("tc_comp_enable", tc_comp_enable_o, exp_trim[14:11] != 4'h0);
    check("tc_shift_positive", tc_shift_positive_o, exp_trim[15]);
    check("tc_shift_step", tc_shift_step_o, exp_trim[14:11]);
  endtask : chk_trim

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_load;
    int n;
    n = 0;
    check("protect_rst", config_protect_bit_o, 1'b0);
    check("freq_rst", ref_freq_trim_o, 10'h000);
    reset_n_i <= 1'b1;
    wb_cyc_i  <= 1'b1;
    wb_stb_i  <= 1'b1;
    wb_adr_i  <= 5'h04;
    while (flash_req_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      check("stall_ack", wb_ack_o, 1'b0);
      n++;
    end
    flash_ack_i  <= 1'b1;
    flash_data_i <= 16'h9E7B;
    exp_trim = 16'h9A7B;
    @(posedge core_clk_i);
    flash_ack_i  <= 1'b0;
    flash_data_i <= 16'h6184;
    n = 0;
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    check("load_read", wb_dat_o, 32'h7B);
    check("flash_req_drop", flash_req_o, 1'b0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
    chk_trim();
  endtask : t_reset_load

  task automatic t_write_fields;
    logic [31:0] v;
    wr(5'h00, 8'hFF);
    wr(5'h04, 8'h3C);
    exp_trim = 16'hFB3C;
    chk_trim();
    wb_xfer(1'b1, 5'h04, 4'hE, 8'h55, v);
    chk_trim();
  endtask : t_write_fields

  task automatic t_protect;
    logic [31:0] v;
    wr(5'h08, 8'h11);
    rd(5'h08, v);
    check("protect_set", v[0], 1'b1);
    check("protect_pin", config_protect_bit_o, 1'b1);
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h00);
    chk_trim();
    wr(5'h08, 8'h26);
    rd(5'h08, v);
    check("protect_clear", v[0], 1'b0);
    wr(5'h04, 8'hA5);
    exp_trim[7:0] = 8'hA5;
    chk_trim();
  endtask : t_protect

  task automatic t_tc_codes;
    logic [4:0] codes [8] = '{5'h00, 5'h10, 5'h01, 5'h0F, 5'h11, 5'h1F, 5'h08, 5'h18};
    foreach (codes[i]) begin
      wr(5'h00, {codes[i], 3'b101});
      exp_trim[15:8] = {codes[i], 3'b001};
      chk_trim();
    end
  endtask : t_tc_codes

  task automatic t_pll_flags;
    logic [31:0] v;
    wr(5'h0C, 8'h01);
    check("pll_select", pll_clock_select_o, 1'b1);
    pll_locked_i <= 1'b1;
    osc_stable_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    rd(5'h0C, v);
    check("status_set", v[2:0], 3'h7);
    wr(5'h04, 8'h12);
    exp_trim[7:0] = 8'h12;
    rd(5'h0C, v);
    check("status_clr", v[2:0], 3'h1);
    check("flags_clr", {pll_lock_flag_o, osc_up_flag_o}, 2'b00);
    pll_locked_i <= 1'b0;
    osc_stable_i <= 1'b0;
    wr(5'h0C, 8'h00);
    repeat (6) @(posedge core_clk_i);
    pll_locked_i <= 1'b1;
    osc_stable_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    wr(5'h00, 8'h40);
    exp_trim[15:8] = 8'h40;
    rd(5'h0C, v);
    check("status_kept", v[2:0], 3'h6);
    chk_trim();
  endtask : t_pll_flags

  task automatic t_unmapped;
    logic [31:0] v;
    rd(5'h10, v);
    check("unmapped_read", v, 32'h0);
    wr(5'h10, 8'hFF);
    chk_trim();
  endtask : t_unmapped

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    reset_n_i    = 1'b0;
    wb_cyc_i     = 1'b0;
    wb_stb_i     = 1'b0;
    wb_we_i      = 1'b0;
    wb_adr_i     = '0;
    wb_sel_i     = 4'h0;
    wb_dat_i     = 32'h0;
    flash_ack_i  = 1'b0;
    flash_data_i = 16'h0000;
    pll_locked_i = 1'b0;
    osc_stable_i = 1'b0;
    exp_trim     = 16'h0000;
    err_count    = 0;
    cmp_count    = 0;
    cyc_cnt      = 0;
    repeat (20) @(posedge core_clk_i);
    t_reset_load();
    t_write_fields();
    t_protect();
    t_tc_codes();
    t_pll_flags();
    t_unmapped();
    complete_run();
  end
endmodule : irt_trim_top_tb_top
